//--- design/condition_code_register.sv
// Condition code register of the processor core with flag update and control outputs.
`timescale 1ns/1ps
`default_nettype none

module condition_code_register (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_clk_en,
	// Whole-word access.
	input  wire logic [1:0]  i_ccr_op,
	input  wire logic [15:0] i_ccr_wdata,
	output logic      [15:0] o_condition_code_word,
	// Flag updates from the execution datapath.
	input  wire logic [2:0]  i_flag_op,
	input  wire logic        i_wide,
	input  wire logic        i_subtract,
	input  wire logic        i_use_carry,
	input  wire logic [15:0] i_operand_a,
	input  wire logic [15:0] i_operand_b,
	input  wire logic [15:0] i_direct_result,
	input  wire logic        i_shift_out,
	output logic      [15:0] o_alu_result,
	output logic             o_shift_in,
	// Multiply-accumulate accumulator.
	input  wire logic        i_mac_update,
	input  wire logic [35:0] i_mac_prev,
	input  wire logic [35:0] i_mac_addend,
	input  wire logic [35:0] i_mac_acc,
	input  wire logic        i_xfer_rounded,
	input  wire logic        i_xfer_truncated,
	output logic      [31:0] o_xfer_data,
	output logic             o_xfer_valid,
	// Low-power halt.
	input  wire logic        i_halt_exec,
	input  wire logic        i_wake,
	output logic             o_stop_clocks,
	output logic             o_halt_as_nop,
	// Interrupts and instruction address.
	input  wire logic        i_irq_request,
	input  wire logic [2:0]  i_irq_level,
	output logic             o_irq_accept,
	input  wire logic [15:0] i_program_counter,
	output logic      [19:0] o_instruction_address
);

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [15:0]            ccr_q;
	logic [15:0]            ccr_d;
	logic                   mac_sign_q;
	ccr_pkg::run_state_type run_q;
	ccr_pkg::ccr_op_type    ccr_op;
	ccr_pkg::flag_op_type   flag_op;

	assign ccr_op  = ccr_pkg::ccr_op_type'(i_ccr_op);
	assign flag_op = ccr_pkg::flag_op_type'(i_flag_op);

	// ---------------------------------------------------------------
	// Named fields
	// ---------------------------------------------------------------
	logic       stop_nop;
	logic       mac_overflow_flag;
	logic       mac_extension_overflow_flag;
	logic       saturation_enable;
	logic [2:0] interrupt_mask_level;
	logic [3:0] program_bank_extension;
	logic       carry_flag;

	// Fixed word layout so software sees every field at a known bit.
	assign stop_nop                    = ccr_q[ccr_pkg::STOP_BIT];
	assign mac_overflow_flag           = ccr_q[ccr_pkg::MAC_OVF_BIT];
	assign mac_extension_overflow_flag = ccr_q[ccr_pkg::MAC_EXT_BIT];
	assign saturation_enable           = ccr_q[ccr_pkg::SAT_BIT];
	assign interrupt_mask_level        = ccr_q[ccr_pkg::MASK_LSB +: ccr_pkg::MASK_WIDTH];
	assign program_bank_extension      = ccr_q[ccr_pkg::BANK_LSB +: ccr_pkg::BANK_WIDTH];
	assign carry_flag                  = ccr_q[ccr_pkg::CARRY_BIT];

	// ---------------------------------------------------------------
	// Arithmetic evaluation
	// ---------------------------------------------------------------
	logic [15:0] alu_sum;
	logic        alu_v;
	logic        alu_c;
	logic        alu_h;

	// The carry flag feeds in only for operations that chain through it.
	alu_flag_eval u_eval (
		.i_operand_a  (i_operand_a),
		.i_operand_b  (i_operand_b),
		.i_carry_in   (i_use_carry & carry_flag),
		.i_subtract   (i_subtract),
		.i_wide       (i_wide),
		.o_result     (alu_sum),
		.o_overflow   (alu_v),
		.o_carry      (alu_c),
		.o_half_carry (alu_h)
	);

	// ---------------------------------------------------------------
	// Value that sets negative and zero
	// ---------------------------------------------------------------
	logic [15:0] nz_value;
	logic        nz_neg;
	logic        nz_zero;

	// Reads test the operand itself; logic and shift results come finished from the datapath.
	always_comb begin
		case (flag_op)
			ccr_pkg::FLAG_READ:  nz_value = i_operand_a;
			ccr_pkg::FLAG_LOGIC: nz_value = i_direct_result;
			ccr_pkg::FLAG_SHIFT: nz_value = i_direct_result;
			default:             nz_value = alu_sum;
		endcase
	end

	assign nz_neg  = i_wide ? nz_value[15] : nz_value[7];
	assign nz_zero = i_wide ? (nz_value == 16'h0000) : (nz_value[7:0] == 8'h00);

	// ---------------------------------------------------------------
	// Accumulator overflow detection
	// ---------------------------------------------------------------
	logic [36:0] mac_sum;
	logic        mac_ovf35;
	logic        mac_ovf31;
	logic        mac_true_sign;

	// A sign-extended 37-bit sum keeps the true sign even when bit 35 overflows.
	assign mac_sum       = {i_mac_prev[35], i_mac_prev} + {i_mac_addend[35], i_mac_addend};
	assign mac_true_sign = mac_sum[36];
	assign mac_ovf35     = mac_sum[36] != mac_sum[35];
	assign mac_ovf31     = mac_sum[36:31] != {6{mac_sum[31]}};

	// ---------------------------------------------------------------
	// Next value of the condition code word
	// ---------------------------------------------------------------
	// A whole-word instruction owns the cycle; otherwise each class touches only its own flags.
	always_comb begin
		ccr_d = ccr_q;
		case (ccr_op)
			ccr_pkg::CCR_LOAD: ccr_d = i_ccr_wdata;
			ccr_pkg::CCR_AND:  ccr_d = ccr_q & i_ccr_wdata;
			ccr_pkg::CCR_OR:   ccr_d = ccr_q | i_ccr_wdata;
			default: begin
				case (flag_op)
					ccr_pkg::FLAG_READ, ccr_pkg::FLAG_LOGIC: begin
						ccr_d[ccr_pkg::NEGATIVE_BIT] = nz_neg;
						ccr_d[ccr_pkg::ZERO_BIT]     = nz_zero;
					end
					ccr_pkg::FLAG_ARITH: begin
						ccr_d[ccr_pkg::NEGATIVE_BIT] = nz_neg;
						ccr_d[ccr_pkg::ZERO_BIT]     = nz_zero;
						ccr_d[ccr_pkg::OVERFLOW_BIT] = alu_v;
						ccr_d[ccr_pkg::CARRY_BIT]    = alu_c;
					end
					ccr_pkg::FLAG_BCD: begin
						ccr_d[ccr_pkg::NEGATIVE_BIT]   = nz_neg;
						ccr_d[ccr_pkg::ZERO_BIT]       = nz_zero;
						ccr_d[ccr_pkg::OVERFLOW_BIT]   = alu_v;
						ccr_d[ccr_pkg::CARRY_BIT]      = alu_c;
						ccr_d[ccr_pkg::HALF_CARRY_BIT] = alu_h;
					end
					ccr_pkg::FLAG_SHIFT: begin
						ccr_d[ccr_pkg::NEGATIVE_BIT] = nz_neg;
						ccr_d[ccr_pkg::ZERO_BIT]     = nz_zero;
						ccr_d[ccr_pkg::CARRY_BIT]    = i_shift_out;
					end
					default: ccr_d = ccr_q;
				endcase
				// The accumulator overflow flag stays set until software clears it.
				if (i_mac_update) begin
					ccr_d[ccr_pkg::MAC_EXT_BIT] = mac_ovf31;
					ccr_d[ccr_pkg::MAC_OVF_BIT] = ccr_q[ccr_pkg::MAC_OVF_BIT] | mac_ovf35;
				end
			end
		endcase
	end

	// Condition code word storage.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ccr_q <= ccr_pkg::CCR_RESET;
		end else if (i_clk_en) begin
			ccr_q <= ccr_d;
		end
	end

	// True sign of the last accumulation sum, bit 36, taken on every update made with no whole-word operation, used to pick the clamp value.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mac_sign_q <= 1'b0;
		end else if (i_clk_en && i_mac_update && ccr_op == ccr_pkg::CCR_NONE) begin
			mac_sign_q <= mac_true_sign;
		end
	end

	// ---------------------------------------------------------------
	// Result register and shift input
	// ---------------------------------------------------------------
	// Sum of the last add or subtract, held until the next one so the core may read it late.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_alu_result <= 16'h0000;
		end else if (i_clk_en && (flag_op == ccr_pkg::FLAG_ARITH || flag_op == ccr_pkg::FLAG_BCD)) begin
			o_alu_result <= alu_sum;
		end
	end

	// Rotates take the old carry into the vacated end.
	assign o_shift_in = carry_flag;

	// ---------------------------------------------------------------
	// Accumulator transfers with saturation
	// ---------------------------------------------------------------
	logic [31:0] xfer_value;
	logic [15:0] xfer_high_rounded;

	// Rounding wraps at the top; saturation covers the overflowed case that matters.
	assign xfer_high_rounded = i_mac_acc[31:16] + {15'h0000, i_mac_acc[15]};

	// Saturation wins over both transfer forms, since a wrapped value is worse than a clamped one.
	always_comb begin
		if (saturation_enable && (mac_overflow_flag || mac_extension_overflow_flag)) begin
			xfer_value = mac_sign_q ? ccr_pkg::SAT_NEGATIVE : ccr_pkg::SAT_POSITIVE;
		end else if (i_xfer_rounded) begin
			xfer_value = {xfer_high_rounded, 16'h0000};
		end else begin
			xfer_value = i_mac_acc[31:0];
		end
	end

	// The valid pulse lasts one cycle; the data holds until the next transfer.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_xfer_data  <= 32'h0000_0000;
			o_xfer_valid <= 1'b0;
		end else if (i_clk_en) begin
			o_xfer_valid <= i_xfer_rounded | i_xfer_truncated;
			if (i_xfer_rounded || i_xfer_truncated) begin
				o_xfer_data <= xfer_value;
			end
		end
	end

	// ---------------------------------------------------------------
	// Low-power halt sequencing
	// ---------------------------------------------------------------
	// The stop request holds until the wake event; a set stop bit turns the halt into a pulse.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_q         <= ccr_pkg::RUN_ACTIVE;
			o_halt_as_nop <= 1'b0;
		end else if (i_clk_en) begin
			o_halt_as_nop <= 1'b0;
			case (run_q)
				ccr_pkg::RUN_ACTIVE: begin
					if (i_halt_exec && !stop_nop) begin
						run_q <= ccr_pkg::RUN_STOPPED;
					end else if (i_halt_exec) begin
						o_halt_as_nop <= 1'b1;
					end
				end
				ccr_pkg::RUN_STOPPED: begin
					if (i_wake) begin
						run_q <= ccr_pkg::RUN_ACTIVE;
					end
				end
				default: run_q <= ccr_pkg::RUN_ACTIVE;
			endcase
		end
	end

	// The stop level comes straight from the state register, never from an input.
	assign o_stop_clocks = (run_q == ccr_pkg::RUN_STOPPED);

	// ---------------------------------------------------------------
	// Interrupt masking and instruction address
	// ---------------------------------------------------------------
	// Both are combinational so a new mask or bank applies from the very next request.
	assign o_irq_accept          = i_irq_request && (i_irq_level > interrupt_mask_level);
	assign o_instruction_address = {program_bank_extension, i_program_counter};

	// Software reads the whole word straight from storage.
	assign o_condition_code_word = ccr_q;

endmodule : condition_code_register
`default_nettype wire

//--- design/ccr_pkg.sv
// Constants, field layout and operation codes of the condition code register.
`default_nettype none
package ccr_pkg;

	// ---------------------------------------------------------------
	// Field positions of the condition code word
	// ---------------------------------------------------------------
	localparam int unsigned STOP_BIT       = 15;
	localparam int unsigned MAC_OVF_BIT    = 14;
	localparam int unsigned HALF_CARRY_BIT = 13;
	localparam int unsigned MAC_EXT_BIT    = 12;
	localparam int unsigned NEGATIVE_BIT   = 11;
	localparam int unsigned ZERO_BIT       = 10;
	localparam int unsigned OVERFLOW_BIT   = 9;
	localparam int unsigned CARRY_BIT      = 8;
	localparam int unsigned MASK_LSB       = 5;
	localparam int unsigned MASK_WIDTH     = 3;
	localparam int unsigned SAT_BIT        = 4;
	localparam int unsigned BANK_LSB       = 0;
	localparam int unsigned BANK_WIDTH     = 4;

	// ---------------------------------------------------------------
	// Widths, value after reset and saturation limits
	// ---------------------------------------------------------------
	localparam int unsigned WORD_WIDTH     = 16;
	localparam int unsigned PC_WIDTH       = 16;
	localparam int unsigned ADDR_WIDTH     = 20;
	localparam int unsigned MAC_WIDTH      = 36;
	localparam int unsigned MAC_OVF_POS    = 35;
	localparam int unsigned MAC_EXT_POS    = 31;
	localparam int unsigned XFER_WIDTH     = 32;
	localparam logic [15:0] CCR_RESET      = 16'h80e0;
	localparam logic [31:0] SAT_POSITIVE   = 32'h7fff_ffff;
	localparam logic [31:0] SAT_NEGATIVE   = 32'h8000_0000;

	// ---------------------------------------------------------------
	// Whole-register operations, flag update classes and run states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		CCR_NONE,
		CCR_LOAD,
		CCR_AND,
		CCR_OR
	} ccr_op_type;

	typedef enum logic [2:0] {
		FLAG_NONE,
		FLAG_READ,
		FLAG_LOGIC,
		FLAG_ARITH,
		FLAG_BCD,
		FLAG_SHIFT
	} flag_op_type;

	typedef enum logic {
		RUN_ACTIVE,
		RUN_STOPPED
	} run_state_type;

endpackage : ccr_pkg
`default_nettype wire

//--- design/alu_flag_eval.sv
// Adder with carry, borrow, overflow and half-carry detection for 8 or 16 bits.
`timescale 1ns/1ps
`default_nettype none

module alu_flag_eval (
	input  wire logic [15:0] i_operand_a,
	input  wire logic [15:0] i_operand_b,
	input  wire logic        i_carry_in,
	input  wire logic        i_subtract,
	input  wire logic        i_wide,
	output logic      [15:0] o_result,
	output logic             o_overflow,
	output logic             o_carry,
	output logic             o_half_carry
);

	// ---------------------------------------------------------------
	// Addition, subtraction done as addition of the complement
	// ---------------------------------------------------------------
	logic [15:0] b_eff;
	logic        cin_eff;
	logic [16:0] sum;
	logic        carry8;
	logic        carry16;
	logic        sign_a;
	logic        sign_b;
	logic        sign_r;

	// A borrow in is an inverted carry in, so subtraction needs no second adder.
	assign b_eff   = i_subtract ? ~i_operand_b : i_operand_b;
	assign cin_eff = i_subtract ? ~i_carry_in : i_carry_in;
	assign sum     = {1'b0, i_operand_a} + {1'b0, b_eff} + {16'h0000, cin_eff};

	// Carry out of a bit position is recovered from the sum bit above it.
	assign carry8  = i_operand_a[8] ^ b_eff[8] ^ sum[8];
	assign carry16 = sum[16];
	assign sign_a  = i_wide ? i_operand_a[15] : i_operand_a[7];
	assign sign_b  = i_wide ? b_eff[15] : b_eff[7];
	assign sign_r  = i_wide ? sum[15] : sum[7];

	// A borrow is reported where the complemented addition made no carry.
	assign o_result     = sum[15:0];
	assign o_carry      = (i_wide ? carry16 : carry8) ^ i_subtract;
	assign o_overflow   = (sign_a == sign_b) && (sign_r != sign_a);
	assign o_half_carry = i_operand_a[4] ^ b_eff[4] ^ sum[4];

endmodule : alu_flag_eval
`default_nettype wire

//--- dv/ccr_props.sv
// Concurrent checks on the ports of the condition code register.
`timescale 1ns/1ps
`default_nettype none

module ccr_props (
	input wire logic        i_clock,
	input wire logic        i_rst_n,
	input wire logic        i_clk_en,
	input wire logic [1:0]  i_ccr_op,
	input wire logic [15:0] i_ccr_wdata,
	input wire logic [15:0] o_condition_code_word,
	input wire logic [2:0]  i_flag_op,
	input wire logic        i_wide,
	input wire logic [15:0] i_operand_a,
	input wire logic        o_shift_in,
	input wire logic        i_mac_update,
	input wire logic [35:0] i_mac_acc,
	input wire logic        i_xfer_rounded,
	input wire logic        i_xfer_truncated,
	input wire logic [31:0] o_xfer_data,
	input wire logic        o_xfer_valid,
	input wire logic        i_halt_exec,
	input wire logic        i_wake,
	input wire logic        o_stop_clocks,
	input wire logic        o_halt_as_nop,
	input wire logic        i_irq_request,
	input wire logic [2:0]  i_irq_level,
	input wire logic        o_irq_accept,
	input wire logic [15:0] i_program_counter,
	input wire logic [19:0] o_instruction_address
);
	// ----------------------------------------------------------------
	// Port relations
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	// Short alias keeps the properties readable.
	logic [15:0] ccr;
	assign ccr = o_condition_code_word;

	a_bank_address: assert property (o_instruction_address == {ccr[3:0], i_program_counter})
		else $error("instruction address does not carry the bank field");
	a_irq_mask: assert property (o_irq_accept == (i_irq_request && (i_irq_level > ccr[7:5])))
		else $error("interrupt accept disagrees with mask level");
	a_shift_carry: assert property (o_shift_in == ccr[8])
		else $error("shift input is not the carry flag");
	a_halt_stop: assert property (i_clk_en && i_halt_exec && !o_stop_clocks && !ccr[15] |=> o_stop_clocks && !o_halt_as_nop)
		else $error("halt with stop bit clear did not stop");
	a_halt_nop: assert property (i_clk_en && i_halt_exec && !o_stop_clocks && ccr[15] |=> o_halt_as_nop && !o_stop_clocks)
		else $error("halt with stop bit set did not run as no-operation");
	a_stop_holds: assert property (o_stop_clocks && !i_wake |=> o_stop_clocks)
		else $error("stop ended without wake");
	a_flag_hold: assert property (i_clk_en && i_ccr_op == 2'h0 && i_flag_op == 3'h0 && !i_mac_update |=> $stable(ccr))
		else $error("word changed with no update requested");
	a_enable_freeze: assert property (!i_clk_en |=> $stable(ccr))
		else $error("word changed while the clock enable was low");
	a_word_load: assert property (i_clk_en && i_ccr_op == 2'h1 |=> ccr == $past(i_ccr_wdata))
		else $error("word load not applied");
	a_read_flags: assert property (i_clk_en && i_ccr_op == 2'h0 && i_flag_op == 3'h1 && i_wide |=> ccr[10] == ($past(i_operand_a) == 16'h0000) && ccr[11] == $past(i_operand_a[15]))
		else $error("read operand flags wrong");
	a_xfer_plain: assert property (i_clk_en && i_xfer_truncated && !i_xfer_rounded && !ccr[4] |=> o_xfer_valid && o_xfer_data == 32'($past(i_mac_acc)))
		else $error("truncated transfer data wrong");
	a_xfer_sat: assert property (i_clk_en && (i_xfer_rounded || i_xfer_truncated) && ccr[4] && (ccr[14] || ccr[12]) && !i_mac_update |=> o_xfer_valid && (o_xfer_data == 32'h7fff_ffff || o_xfer_data == 32'h8000_0000))
		else $error("saturated transfer not clamped");

	// Main scenarios that the bench is expected to reach.
	c_stop_wake: cover property (o_stop_clocks ##1 !o_stop_clocks);
	c_sat_xfer: cover property (o_xfer_valid && ccr[4] && ccr[14]);
	c_irq_accept: cover property (o_irq_accept);
endmodule : ccr_props

bind condition_code_register ccr_props u_ccr_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
	.i_ccr_op(i_ccr_op), .i_ccr_wdata(i_ccr_wdata), .o_condition_code_word(o_condition_code_word),
	.i_flag_op(i_flag_op), .i_wide(i_wide), .i_operand_a(i_operand_a), .o_shift_in(o_shift_in),
	.i_mac_update(i_mac_update), .i_mac_acc(i_mac_acc), .i_xfer_rounded(i_xfer_rounded),
	.i_xfer_truncated(i_xfer_truncated), .o_xfer_data(o_xfer_data), .o_xfer_valid(o_xfer_valid),
	.i_halt_exec(i_halt_exec), .i_wake(i_wake), .o_stop_clocks(o_stop_clocks), .o_halt_as_nop(o_halt_as_nop),
	.i_irq_request(i_irq_request), .i_irq_level(i_irq_level), .o_irq_accept(o_irq_accept),
	.i_program_counter(i_program_counter), .o_instruction_address(o_instruction_address));
`default_nettype wire

//--- dv/wake_model.sv
// Behavioural sequencer that wakes a stopped core after a set delay.
`timescale 1ns/1ps
`default_nettype none

module wake_model #(
	parameter int WAKE_DELAY = 4
) (
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_stop_clocks,
	output logic      o_wake
);
	logic [7:0] wait_q;

	// Wake is held as a level until the core runs again, so a slow core still sees it.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_q <= 8'h00;
			o_wake <= 1'b0;
		end else begin
			wait_q <= i_stop_clocks ? wait_q + 8'h01 : 8'h00;
			o_wake <= i_stop_clocks && (wait_q >= 8'(WAKE_DELAY));
		end
	end
endmodule : wake_model
`default_nettype wire

//--- dv/condition_code_register_tb.sv
// Self-checking testbench of the condition code register.
`timescale 1ns/1ps
`default_nettype none

module condition_code_register_tb;
	logic        i_clock, i_rst_n, i_clk_en, i_wide, i_subtract, i_use_carry, i_shift_out;
	logic        i_mac_update, i_xfer_rounded, i_xfer_truncated, i_halt_exec, i_wake, i_irq_request;
	logic [1:0]  i_ccr_op;
	logic [2:0]  i_flag_op, i_irq_level;
	logic [15:0] i_ccr_wdata, i_operand_a, i_operand_b, i_direct_result, i_program_counter;
	logic [35:0] i_mac_prev, i_mac_addend, i_mac_acc;
	logic [15:0] o_condition_code_word, o_alu_result;
	logic [31:0] o_xfer_data;
	logic [19:0] o_instruction_address;
	logic        o_shift_in, o_xfer_valid, o_stop_clocks, o_halt_as_nop, o_irq_accept;
	int          n_fail, checks;

	condition_code_register u_condition_code_register (.i_clock, .i_rst_n, .i_clk_en, .i_ccr_op, .i_ccr_wdata,
		.o_condition_code_word, .i_flag_op, .i_wide, .i_subtract, .i_use_carry, .i_operand_a, .i_operand_b,
		.i_direct_result, .i_shift_out, .o_alu_result, .o_shift_in, .i_mac_update, .i_mac_prev, .i_mac_addend,
		.i_mac_acc, .i_xfer_rounded, .i_xfer_truncated, .o_xfer_data, .o_xfer_valid, .i_halt_exec, .i_wake,
		.o_stop_clocks, .o_halt_as_nop, .i_irq_request, .i_irq_level, .o_irq_accept, .i_program_counter,
		.o_instruction_address);
	wake_model u_wake_model (.i_clock, .i_rst_n, .i_stop_clocks(o_stop_clocks), .o_wake(i_wake));

	// ----------------------------------------------------------------
	// Clock, comparisons and access tasks
	// ----------------------------------------------------------------
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	task automatic close_out;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t data %h expected %h", $time, got, exp);
		end
	endtask : chk_data

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t bit %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	// Inputs move a fixed 1 ns after the edge so the design never races the bench.
	task automatic cyc;
		@(posedge i_clock);
		#1;
	endtask : cyc

	// Every request is followed by an idle cycle so no strobe is lowered and raised in one step.
	task automatic wop(input logic [1:0] op, input logic [15:0] d);
		i_ccr_op = op;
		i_ccr_wdata = d;
		cyc();
		i_ccr_op = 2'h0;
		cyc();
	endtask : wop

	task automatic fop(input logic [2:0] op, input logic w, s, input logic [15:0] a, b, r, input logic so);
		i_flag_op = op;
		i_wide = w;
		i_subtract = s;
		i_operand_a = a;
		i_operand_b = b;
		i_direct_result = r;
		i_shift_out = so;
		cyc();
		i_flag_op = 3'h0;
		cyc();
	endtask : fop

	task automatic mac(input logic [35:0] p, input logic [35:0] d);
		i_mac_prev = p;
		i_mac_addend = d;
		i_mac_update = 1'b1;
		cyc();
		i_mac_update = 1'b0;
		cyc();
	endtask : mac

	// The valid pulse stands one cycle only, so it is looked at right after the taking edge.
	task automatic xfer(input logic r, input logic [35:0] acc, input logic [31:0] exp);
		i_xfer_rounded = r;
		i_xfer_truncated = !r;
		i_mac_acc = acc;
		cyc();
		chk_bit(o_xfer_valid, 1'b1);
		chk_data(o_xfer_data, exp);
		i_xfer_rounded = 1'b0;
		i_xfer_truncated = 1'b0;
		cyc();
	endtask : xfer

	task automatic halt(input logic es, input logic en);
		i_halt_exec = 1'b1;
		cyc();
		chk_bit(o_stop_clocks, es);
		chk_bit(o_halt_as_nop, en);
		i_halt_exec = 1'b0;
		cyc();
	endtask : halt

	// A hang counts as a mismatch and ends the run through the same verdict.
	initial begin
		#20000;
		n_fail++;
		$display("ERROR %0t watchdog expired", $time);
		close_out();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{i_wide, i_subtract, i_use_carry, i_shift_out, i_mac_update, i_xfer_rounded} = 6'h00;
		{i_xfer_truncated, i_halt_exec, i_irq_request, i_ccr_op, i_flag_op, i_irq_level} = 11'h000;
		{i_ccr_wdata, i_operand_a, i_operand_b, i_direct_result, i_program_counter} = 80'h0;
		{i_mac_prev, i_mac_addend, i_mac_acc} = 108'h0;
		n_fail = 0;
		checks = 0;
		i_clk_en = 1'b1;
		i_rst_n = 1'b0;
		repeat (6) @(posedge i_clock);
		#1 i_rst_n = 1'b1;
		chk_word(o_condition_code_word, ccr_pkg::CCR_RESET);
		wop(ccr_pkg::CCR_LOAD, 16'h5a3c);
		chk_word(o_condition_code_word, 16'h5a3c);
		wop(ccr_pkg::CCR_AND, 16'h0ff0);
		chk_word(o_condition_code_word, 16'h0a30);
		wop(ccr_pkg::CCR_OR, 16'h8001);
		chk_word(o_condition_code_word, 16'h8a31);
		wop(ccr_pkg::CCR_LOAD, 16'h000b);
		i_program_counter = 16'h1234;
		cyc();
		chk_data({12'h000, o_instruction_address}, 32'h000b_1234);
		wop(ccr_pkg::CCR_LOAD, 16'h0060);
		i_irq_request = 1'b1;
		for (int l = 0; l < 8; l++) begin
			i_irq_level = 3'(l);
			cyc();
			chk_bit(o_irq_accept, l > 3);
		end
		wop(ccr_pkg::CCR_LOAD, 16'h00e0);
		chk_bit(o_irq_accept, 1'b0);
		i_irq_request = 1'b0;
		wop(ccr_pkg::CCR_LOAD, 16'h0000);
		fop(3'h3, 1'b1, 1'b0, 16'h7fff, 16'h0001, 16'h0000, 1'b0);
		chk_word(o_condition_code_word, 16'h0a00);
		chk_word(o_alu_result, 16'h8000);
		fop(3'h3, 1'b0, 1'b1, 16'h0000, 16'h0001, 16'h0000, 1'b0);
		chk_word(o_condition_code_word, 16'h0900);
		fop(3'h3, 1'b1, 1'b0, 16'hffff, 16'h0001, 16'h0000, 1'b0);
		chk_word(o_condition_code_word, 16'h0500);
		fop(3'h4, 1'b0, 1'b0, 16'h0008, 16'h0008, 16'h0000, 1'b0);
		chk_word(o_condition_code_word, 16'h2000);
		fop(3'h4, 1'b0, 1'b0, 16'h0001, 16'h0008, 16'h0000, 1'b0);
		chk_word(o_condition_code_word, 16'h0000);
		wop(ccr_pkg::CCR_LOAD, 16'h0200);
		fop(3'h2, 1'b1, 1'b0, 16'h0001, 16'h0000, 16'h0000, 1'b0);
		chk_word(o_condition_code_word, 16'h0600);
		fop(3'h5, 1'b1, 1'b0, 16'h0000, 16'h0000, 16'h8000, 1'b1);
		chk_word(o_condition_code_word, 16'h0b00);
		chk_bit(o_shift_in, 1'b1);
		fop(3'h1, 1'b1, 1'b0, 16'h0000, 16'h0000, 16'h1234, 1'b0);
		chk_word(o_condition_code_word, 16'h0700);
		i_use_carry = 1'b1;
		fop(3'h3, 1'b1, 1'b0, 16'h0001, 16'h0001, 16'h0000, 1'b0);
		i_use_carry = 1'b0;
		chk_word(o_alu_result, 16'h0003);
		chk_word(o_condition_code_word, 16'h0000);
		wop(ccr_pkg::CCR_LOAD, 16'h0000);
		mac(36'h0_7fff_ffff, 36'h0_0000_0001);
		chk_word(o_condition_code_word, 16'h1000);
		mac(36'h7_ffff_ffff, 36'h0_0000_0001);
		chk_bit(o_condition_code_word[14], 1'b1);
		wop(ccr_pkg::CCR_OR, 16'h0010);
		xfer(1'b0, 36'h8_0000_0000, ccr_pkg::SAT_POSITIVE);
		wop(ccr_pkg::CCR_LOAD, 16'h0010);
		mac(36'h8_0000_0000, 36'hf_ffff_ffff);
		chk_bit(o_condition_code_word[14], 1'b1);
		xfer(1'b1, 36'h0_1234_8000, ccr_pkg::SAT_NEGATIVE);
		wop(ccr_pkg::CCR_LOAD, 16'h0000);
		xfer(1'b0, 36'h0_1234_5678, 32'h1234_5678);
		xfer(1'b1, 36'h0_1234_8000, 32'h1235_0000);
		halt(1'b1, 1'b0);
		for (int k = 0; k < 20 && o_stop_clocks === 1'b1; k++) begin
			cyc();
		end
		chk_bit(o_stop_clocks, 1'b0);
		wop(ccr_pkg::CCR_LOAD, 16'h8000);
		halt(1'b0, 1'b1);
		i_clk_en = 1'b0;
		wop(ccr_pkg::CCR_LOAD, 16'h1234);
		chk_word(o_condition_code_word, 16'h8000);
		i_clk_en = 1'b1;
		i_rst_n = 1'b0;
		cyc();
		i_rst_n = 1'b1;
		chk_word(o_condition_code_word, ccr_pkg::CCR_RESET);
		chk_data(o_xfer_data, 32'h0000_0000);
		close_out();
	end
endmodule : condition_code_register_tb
`default_nettype wire
